// ===== inc/lin_cfg_pkg.sv
`default_nettype none

package lin_cfg_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SIZE = 8'h0b;
    localparam logic [7:0] IDX_DIV = 8'h0c;
    localparam logic [7:0] IDX_MUL = 8'h0d;
    localparam logic [7:0] IDX_ID = 8'h0e;
    // Reset values
    localparam logic [7:0] SIZE_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET = 8'hff;
    localparam logic [7:0] MUL_RESET = 8'hff;
    localparam logic [7:0] ID_RESET = 8'h00;
    // Field positions
    localparam int CHK_MODE_BIT = 7;
    localparam int LEN_MSB = 3;
    localparam int DIV_HIGH_BIT = 0;
    localparam int MUL_LSB = 1;
    localparam int MUL_MSB = 5;
    localparam int PRE_LSB = 6;
    localparam int PRE_MSB = 7;
    localparam int ID_MSB = 5;
    localparam int ID_LEN_LSB = 4;
    // Length code meanings
    localparam logic [3:0] LEN_CODE_MAX = 4'h8;
    localparam logic [3:0] LEN_CODE_IDENT = 4'hf;
    localparam logic [3:0] LEN_IDENT_SHORT = 4'h2;
    localparam logic [3:0] LEN_IDENT_MID = 4'h4;
    localparam logic [3:0] LEN_IDENT_LONG = 4'h8;

    // Frame engine events towards this block
    typedef struct packed {
        logic start;
        logic [7:0] pid;
        logic data_valid;
        logic [7:0] data;
        logic chk_valid;
        logic [7:0] chk;
    } frame_in_s;

    // Per-frame settings latched at frame start
    typedef struct packed {
        logic [3:0] byte_count;
        logic enhanced;
        logic [5:0] ident;
    } frame_cfg_s;

    // Rate generation settings
    typedef struct packed {
        logic [8:0] divider;
        logic [4:0] multiplier;
        logic [1:0] prescale;
    } rate_cfg_s;
endpackage

`default_nettype wire

// ===== hdl/lin_frame_rate_config.sv
// What this block does
// - Mode 0: checksum sums data bytes only
// - Mode 1: checksum also includes protected identifier
// - Size bits 6:4 read zero, writes ignored
// - Length codes 0-8 give 0-8 bytes
// - Code 1111 takes length from identifier
// - Identifier bits 5:4 give 2,2,4,8 bytes
// - Identifier six bits; bits 7:6 read zero
// - Divider is nine bits, top from multiplier
// - Multiplier used only in master mode
// - Prescaler bits 7:6 feed rate generation
// - Flag error when received checksum mismatches
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

module lin_frame_rate_config (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic master_mode,
    input wire lin_cfg_pkg::frame_in_s frame_in,
    output lin_cfg_pkg::frame_cfg_s frame_cfg,
    output lin_cfg_pkg::rate_cfg_s rate_cfg,
    output logic [7:0] checksum_value,
    output logic checksum_error
);

    // Bus data phase states
    typedef enum logic [1:0] {
        st_idle,
        st_write,
        st_read_wait,
        st_read_done
    } bus_state_e;

    bus_state_e state; // Current data phase
    bus_state_e next_state; // Following data phase
    logic take; // Address phase accepted this edge
    logic [7:0] addr_idx; // Register index of the pending access
    logic addr_hit; // Upper address bits were zero
    logic chk_mode; // Checksum mode select
    logic [3:0] len_code; // Data length code
    logic [7:0] div_low; // Low divider bits
    logic [7:0] mul_reg; // Prescale, multiplier and divider top bit
    logic [5:0] ident; // Frame identifier bits
    logic [7:0] sum; // Running checksum sum with end-around carry
    logic [7:0] next_sum; // Sum after this edge's start or data byte
    logic [7:0] rd_mux; // Read value selected by index

    // Effective data length for a length code and identifier
    function automatic logic [3:0] eff_len(input logic [3:0] code, input logic [5:0] id);
        logic [1:0] top;
        top = id[lin_cfg_pkg::ID_MSB:lin_cfg_pkg::ID_LEN_LSB];
        if (code == lin_cfg_pkg::LEN_CODE_IDENT) begin
            unique case (top)
                2'b10: return lin_cfg_pkg::LEN_IDENT_MID;
                2'b11: return lin_cfg_pkg::LEN_IDENT_LONG;
                default: return lin_cfg_pkg::LEN_IDENT_SHORT;
            endcase
        end else if (code > lin_cfg_pkg::LEN_CODE_MAX) begin
            // Reserved codes clamp to the largest field
            return lin_cfg_pkg::LEN_CODE_MAX;
        end else begin
            return code;
        end
    endfunction

    // Eight-bit add with the carry folded back in
    function automatic logic [7:0] add_carry(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction

    // Only nonseq and seq transfers are taken, idle and busy are not; responses are always OKAY
    assign take = hsel && hready && htrans[1];
    assign hresp = 1'b0;
    // Reads hold the bus one cycle while the data register loads
    assign hreadyout = (state != st_read_wait);

    // Next data phase
    always_comb begin
        next_state = st_idle;
        unique case (state)
            st_read_wait: begin
                next_state = st_read_done;
            end
            st_idle, st_write, st_read_done: begin
                if (take) begin
                    next_state = hwrite ? st_write : st_read_wait;
                end
            end
        endcase
    end

    // Data phase state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_idx <= 8'h00;
            addr_hit <= 1'b0;
        end else if (take) begin
            addr_idx <= haddr[9:2];
            addr_hit <= (haddr[31:10] == 22'h000000);
        end
    end

    // Size register: mode bit and length code; bits 6:4 are not stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chk_mode <= lin_cfg_pkg::SIZE_RESET[lin_cfg_pkg::CHK_MODE_BIT];
            len_code <= lin_cfg_pkg::SIZE_RESET[lin_cfg_pkg::LEN_MSB:0];
        end else if (state == st_write && addr_hit && addr_idx == lin_cfg_pkg::IDX_SIZE) begin
            chk_mode <= hwdata[lin_cfg_pkg::CHK_MODE_BIT];
            len_code <= hwdata[lin_cfg_pkg::LEN_MSB:0];
        end
    end

    // Divider low bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_low <= lin_cfg_pkg::DIV_RESET;
        end else if (state == st_write && addr_hit && addr_idx == lin_cfg_pkg::IDX_DIV) begin
            div_low <= hwdata[7:0];
        end
    end

    // Multiplier register, all eight bits writable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mul_reg <= lin_cfg_pkg::MUL_RESET;
        end else if (state == st_write && addr_hit && addr_idx == lin_cfg_pkg::IDX_MUL) begin
            mul_reg <= hwdata[7:0];
        end
    end

    // Identifier, six bits stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ident <= lin_cfg_pkg::ID_RESET[lin_cfg_pkg::ID_MSB:0];
        end else if (state == st_write && addr_hit && addr_idx == lin_cfg_pkg::IDX_ID) begin
            ident <= hwdata[lin_cfg_pkg::ID_MSB:0];
        end
    end

    // Read value; unused bits and unmapped addresses read zero
    always_comb begin
        rd_mux = 8'h00;
        if (addr_hit) begin
            unique case (addr_idx)
                lin_cfg_pkg::IDX_SIZE: rd_mux = {chk_mode, 3'h0, len_code};
                lin_cfg_pkg::IDX_DIV: rd_mux = div_low;
                lin_cfg_pkg::IDX_MUL: rd_mux = mul_reg;
                lin_cfg_pkg::IDX_ID: rd_mux = {2'h0, ident};
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // Read data register, loaded in the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (state == st_read_wait) begin
            hrdata <= {24'h000000, rd_mux};
        end
    end

    // Per-frame settings, taken only at frame start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_cfg <= '0;
        end else if (frame_in.start) begin
            frame_cfg.byte_count <= eff_len(len_code, ident);
            frame_cfg.enhanced <= chk_mode;
            frame_cfg.ident <= ident;
        end
    end

    // Rate settings; multiplier forced to zero outside master mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_cfg.divider <= {lin_cfg_pkg::MUL_RESET[lin_cfg_pkg::DIV_HIGH_BIT],
                                 lin_cfg_pkg::DIV_RESET};
            rate_cfg.multiplier <= 5'h00;
            rate_cfg.prescale <= lin_cfg_pkg::MUL_RESET[lin_cfg_pkg::PRE_MSB:lin_cfg_pkg::PRE_LSB];
        end else begin
            rate_cfg.divider <= {mul_reg[lin_cfg_pkg::DIV_HIGH_BIT], div_low};
            rate_cfg.multiplier <= master_mode ?
                mul_reg[lin_cfg_pkg::MUL_MSB:lin_cfg_pkg::MUL_LSB] : 5'h00;
            rate_cfg.prescale <= mul_reg[lin_cfg_pkg::PRE_MSB:lin_cfg_pkg::PRE_LSB];
        end
    end

    // Next running sum, seeded by mode at frame start; start wins over a byte
    always_comb begin
        next_sum = sum;
        if (frame_in.start) begin
            // Enhanced seeds with the identifier, classic with zero
            next_sum = chk_mode ? frame_in.pid : 8'h00;
        end else if (frame_in.data_valid) begin
            next_sum = add_carry(sum, frame_in.data);
        end
    end

    // Checksum accumulator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sum <= 8'h00;
        end else begin
            sum <= next_sum;
        end
    end

    // Checksum to send, kept in its own flop as the inverted sum
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            checksum_value <= 8'hff;
        end else begin
            checksum_value <= ~next_sum;
        end
    end

    // Mismatch pulse one cycle after the received checksum
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            checksum_error <= 1'b0;
        end else begin
            checksum_error <= frame_in.chk_valid && (frame_in.chk != ~sum);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Size readback keeps unused bits clear
    a_size_reserved_zero: assert property (
        state == st_read_wait && addr_hit && addr_idx == lin_cfg_pkg::IDX_SIZE
        |=> hrdata[6:4] == 3'h0 && hrdata[3:0] == $past(len_code))
        else $error("size reserved bits not zero");

    // Identifier readback keeps top bits clear
    a_ident_upper_zero: assert property (
        state == st_read_wait && addr_hit && addr_idx == lin_cfg_pkg::IDX_ID
        |=> hrdata[7:6] == 2'h0 && hrdata[5:0] == $past(ident))
        else $error("identifier readback wrong");

    // Direct codes give their own byte count
    a_len_direct_count: assert property (
        frame_in.start && len_code <= lin_cfg_pkg::LEN_CODE_MAX
        |=> frame_cfg.byte_count == $past(len_code))
        else $error("direct length wrong");

    // Identifier-derived length decode
    a_len_ident_decode: assert property (
        frame_in.start && len_code == lin_cfg_pkg::LEN_CODE_IDENT
        |=> frame_cfg.byte_count == ($past(ident[5]) ? ($past(ident[4]) ? 4'h8 : 4'h4) : 4'h2))
        else $error("identifier length wrong");

    // Derived length ignores the length field itself
    a_len_ident_select: assert property (
        frame_in.start && len_code == lin_cfg_pkg::LEN_CODE_IDENT && ident[5:4] == 2'b11
        |=> frame_cfg.byte_count == 4'h8 ##1 frame_cfg.byte_count == 4'h8 || $past(frame_in.start))
        else $error("code 1111 not using identifier");

    // Divider combines both registers
    a_divider_join: assert property (
        ##1 rate_cfg.divider == {$past(mul_reg[0]), $past(div_low)})
        else $error("divider not joined");

    // Multiplier silent in slave mode
    a_mult_slave_zero: assert property (
        !master_mode |=> rate_cfg.multiplier == 5'h00)
        else $error("multiplier active in slave mode");

    // Prescaler follows its field
    a_prescale_follow: assert property (
        ##1 rate_cfg.prescale == $past(mul_reg[7:6]))
        else $error("prescale mismatch");

    // Classic mode starts from zero
    a_classic_seed: assert property (
        frame_in.start && !chk_mode |=> sum == 8'h00)
        else $error("classic seed not zero");

    // Enhanced mode starts from the identifier
    a_enhanced_seed: assert property (
        frame_in.start && chk_mode |=> sum == $past(frame_in.pid))
        else $error("enhanced seed not identifier");

    // Mismatch raises the error, match does not
    a_chk_error_flag: assert property (
        frame_in.chk_valid |=> checksum_error == ($past(frame_in.chk) != ~$past(sum)))
        else $error("checksum error flag wrong");

    // Settings stay fixed between frame starts
    a_frame_hold: assert property (
        !frame_in.start |=> $stable(frame_cfg))
        else $error("frame settings changed mid frame");

    // Main scenarios
    c_ident_length: cover property (frame_in.start && len_code == lin_cfg_pkg::LEN_CODE_IDENT);
    c_enhanced_frame: cover property (frame_in.start && chk_mode);
    c_chk_error: cover property (checksum_error);
    c_write_then_read: cover property (state == st_write ##2 state == st_read_wait);

endmodule // lin_frame_rate_config

`default_nettype wire

// ===== tb/lin_frame_source.sv
`timescale 1ns/1ns
`default_nettype none

// Stand-in for the frame engine: start, data and checksum events
module lin_frame_source (
    input wire logic hclk,
    output lin_cfg_pkg::frame_in_s fr
);
    // Quiet at time zero
    initial begin
        fr = '0;
    end

    // Start pulse with the protected identifier
    task automatic start_frame(input logic [7:0] pid);
        fr.start <= 1'b1;
        fr.pid <= pid;
        @(posedge hclk);
        fr.start <= 1'b0;
        fr.pid <= ~pid; // Released byte no longer shows its value
    endtask

    // Data bytes back to back, one per cycle
    task automatic send_bytes(input int n, input logic [7:0] b[8]);
        for (int i = 0; i < n; i++) begin
            fr.data_valid <= 1'b1;
            fr.data <= b[i];
            @(posedge hclk);
        end
        fr.data_valid <= 1'b0;
        fr.data <= ~fr.data; // Idle data shows the inverse
    endtask

    // Received checksum byte
    task automatic send_chk(input logic [7:0] c);
        fr.chk_valid <= 1'b1;
        fr.chk <= c;
        @(posedge hclk);
        fr.chk_valid <= 1'b0;
        fr.chk <= ~c;
    endtask
endmodule // lin_frame_source

`default_nettype wire

// ===== tb/lin_frame_rate_config_tb.sv
`timescale 1ns/1ns
`default_nettype none

// Self-checking bench for the LIN configuration block
module lin_frame_rate_config_tb;
    logic hclk, hresetn, hsel, hwrite, master_mode, hreadyout, hresp, checksum_error;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] checksum_value;
    lin_cfg_pkg::frame_in_s frame_in;
    lin_cfg_pkg::frame_cfg_s frame_cfg;
    lin_cfg_pkg::rate_cfg_s rate_cfg;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int regs[4]; // Register model: size, divider, multiplier, identifier
    logic [31:0] seed = 32'h00014bf3;

    lin_frame_rate_config lin_frame_rate_config_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .master_mode(master_mode),
        .frame_in(frame_in), .frame_cfg(frame_cfg), .rate_cfg(rate_cfg),
        .checksum_value(checksum_value), .checksum_error(checksum_error)
    );
    lin_frame_source lin_frame_source_inst (.hclk(hclk), .fr(frame_in));

    // Free-running clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // Hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict
    task automatic finish_test();
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Wait for hready sampled high, returning read data of that edge
    task automatic wait_ready(output logic [31:0] rd);
        logic r;
        do begin
            @(negedge hclk);
            r = hreadyout;
            rd = hrdata;
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask

    // One single-word AHB-Lite transfer at register index idx
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready(rd);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready(rd);
    endtask

    // Write with model update for mapped indices
    task automatic wr(input logic [7:0] idx, input int v);
        logic [31:0] rd;
        xfer(1'b1, idx, v, rd);
        if (idx >= 8'h0b && idx <= 8'h0e) begin
            regs[idx - 8'h0b] = idx == 8'h0b ? v & 32'h8f : idx == 8'h0e ? v & 32'h3f : v & 32'hff;
        end
    endtask

    // Read and compare against the model
    task automatic rd_chk(input logic [7:0] idx);
        logic [31:0] rd;
        xfer(1'b0, idx, 32'h0, rd);
        check(rd, (idx >= 8'h0b && idx <= 8'h0e) ? regs[idx - 8'h0b] : 0);
    endtask

    // Effective length from code and identifier
    function automatic int exp_len(int code, int id);
        if (code != 15) return code;
        return ((id >> 4) & 3) == 3 ? 8 : ((id >> 4) & 3) == 2 ? 4 : 2;
    endfunction

    initial begin
        logic [7:0] b[8];
        int code, n, s, d, m, en, idv, pidv;
        bit bad;
        regs = '{32'h00, 32'hff, 32'hff, 32'h00};
        {hresetn, hsel, hwrite, master_mode, htrans} = '0;
        haddr = 32'h0;
        hwdata = 32'h0;
        hsize = 3'h2;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, then unmapped index
        for (int i = 8'h0b; i <= 8'h0f; i++) rd_chk(i[7:0]);
        // Reserved bits ignore writes, unmapped write has no effect
        for (int i = 8'h0b; i <= 8'h0f; i++) wr(i[7:0], 32'hff);
        for (int i = 8'h0b; i <= 8'h0f; i++) rd_chk(i[7:0]);
        // Rate settings in both node modes, divider kept in range
        for (int k = 0; k < 8; k++) begin
            d = 200 + rnd() % 312;
            m = (rnd() & 32'hfe) | (d >> 8);
            master_mode <= k[0];
            wr(8'h0c, d & 255);
            wr(8'h0d, m);
            repeat (2) @(posedge hclk);
            @(negedge hclk);
            check(rate_cfg.divider, d);
            check(rate_cfg.prescale, m >> 6);
            check(rate_cfg.multiplier, k[0] ? (m >> 1) & 31 : 0);
            @(posedge hclk);
        end
        // Frames over length codes 0-8 and 1111, both checksum modes
        for (int k = 0; k < 14; k++) begin
            code = k <= 8 ? k : 15;
            idv = k <= 8 ? rnd() & 63 : (k - 9) << 4 | (rnd() & 15);
            en = rnd() & 1;
            wr(8'h0b, en << 7 | code);
            wr(8'h0e, idv);
            n = exp_len(code, idv);
            pidv = rnd() & 255;
            lin_frame_source_inst.start_frame(pidv[7:0]);
            // Mid-frame writes must not disturb the frame
            wr(8'h0b, 32'h8f ^ (en << 7));
            wr(8'h0e, ~idv);
            @(negedge hclk);
            check(frame_cfg, {n[3:0], en[0], idv[5:0]});
            s = en ? pidv : 0;
            for (int i = 0; i < 8; i++) begin
                b[i] = rnd();
                if (i < n) s = s + b[i];
                if (s > 255) s = s - 255;
            end
            @(posedge hclk);
            lin_frame_source_inst.send_bytes(n, b);
            @(negedge hclk);
            check(checksum_value, s[7:0] ^ 8'hff);
            bad = k[0];
            @(posedge hclk);
            lin_frame_source_inst.send_chk(~s[7:0] ^ {7'h0, bad});
            @(negedge hclk);
            check(checksum_error, bad);
            @(posedge hclk);
        end
        finish_test();
    end
endmodule // lin_frame_rate_config_tb

`default_nettype wire
